// ==== design/ajlc_regs.vh ====
// Register map, field positions and reset values of the link configuration bank.
`ifndef AJLC_REGS_VH
`define AJLC_REGS_VH

// ****************************************************************
// Register addresses
// ****************************************************************
`define AJLC_ADDR_CONVERTER_CONTROL 7'h02
`define AJLC_ADDR_LINK_DEVICE_IDENTIFIER         7'h03
`define AJLC_ADDR_LINK_BANK_IDENTIFIER           7'h04
`define AJLC_ADDR_LANE_COUNT        7'h05
`define AJLC_ADDR_MULTIFRAME_LEN    7'h06
`define AJLC_ADDR_LINK_MODES        7'h07

// ****************************************************************
// Field positions
// ****************************************************************
`define AJLC_BIT_CLOCK_HALVING      2
`define AJLC_BIT_OVERFLOW_EN        1
`define AJLC_BIT_DUTY_STAB_EN       0
`define AJLC_BIT_ALIGN_SEQ_DIS      5
`define AJLC_BIT_LANE_MON_DIS       4
`define AJLC_BIT_FRAME_MON_DIS      3
`define AJLC_BIT_RESERVED_ZERO      2
`define AJLC_BIT_DIV_RESET_DIS      1
`define AJLC_BIT_SCRAMBLER_EN       0

// ****************************************************************
// Reset values
// ****************************************************************
`define AJLC_RST_CONVERTER_CONTROL  3'h0
`define AJLC_RST_LINK_DEVICE_IDENTIFIER          8'h00
`define AJLC_RST_LINK_BANK_IDENTIFIER            4'h0
`define AJLC_RST_LANE_COUNT         3'h1
`define AJLC_RST_MULTIFRAME_LEN     5'h0F
`define AJLC_RST_LINK_MODES         6'h00
`define AJLC_RST_LANE_ENABLE        4'h3
`define AJLC_RST_PINS               5'h11

// ****************************************************************
// Serial frame layout and subclass codes
// ****************************************************************
`define AJLC_FRAME_CMD_LAST         5'h07
`define AJLC_FRAME_DATA_LAST        5'h0F
`define AJLC_FRAME_DONE             5'h10
`define AJLC_SUBCLASS_1             3'h1
`define AJLC_SUBCLASS_2             3'h2

`endif

// ==== design/ajlc_pin_filter.v ====
// Three-stage pin synchroniser with agreement filter for asynchronous inputs.
`timescale 1ns/10ps
`default_nettype none

module ajlc_pin_filter #(
	parameter       WIDTH     = 5,
	parameter [4:0] RESET_VAL = 5'h00
) (
	input  wire             core_clk,  // Core clock.
	input  wire             rstn,      // Asynchronous reset, active low.
	input  wire [WIDTH-1:0] pin_in,    // Raw pin levels.
	output wire [WIDTH-1:0] pin_out    // Filtered levels.
);

	// ****************************************************************
	// Per-pin stages
	// ****************************************************************
	// A level is accepted only once the second and third stages agree, so a
	// pin caught mid-transition never reaches the serial decoder as a glitch.
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg filt_q;

			always @(posedge core_clk or negedge rstn) begin
				if (!rstn) begin
					s1_q   <= RESET_VAL[i];
					s2_q   <= RESET_VAL[i];
					s3_q   <= RESET_VAL[i];
					filt_q <= RESET_VAL[i];
				end else begin
					s1_q <= pin_in[i];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						filt_q <= s3_q;
					end
				end
			end

			assign pin_out[i] = filt_q;
		end
	endgenerate

endmodule // ajlc_pin_filter

`default_nettype wire

// ==== design/ajlc_link_config.v ====
// Serial-port register bank holding the converter and link configuration.
`timescale 1ns/10ps
`default_nettype none
`include "ajlc_regs.vh"

module ajlc_link_config (
	input  wire       core_clk,                    // Core clock, 25 MHz.
	input  wire       rstn,                        // Asynchronous reset, active low.
	input  wire       spi_cs_n,                    // Serial chip select, active low.
	input  wire       spi_sck,                     // Serial clock pin.
	input  wire       spi_sdi,                     // Serial data in.
	output wire       spi_sdo_o,                   // Serial data out level, always low.
	output wire       spi_sdo_oe,                  // Pull-down enable of open-drain out.
	input  wire       sysref,                      // System reference pin.
	input  wire       sync_n,                      // Synchronisation request, active low.
	input  wire [2:0] subclass_select,             // Subclass from the subclass register.
	input  wire       overflow_raw,                // Overflow flag from the converter.
	output wire       clock_halving_select,        // Converter clock is twice sample rate.
	output wire       overflow_output_enable,      // Overflow output enabled.
	output wire       duty_stabilizer_enable,      // Duty cycle stabilizer enabled.
	output wire [7:0] link_device_identifier,      // Device identifier for alignment.
	output wire [3:0] link_bank_identifier,        // Bank identifier for alignment.
	output wire [2:0] lane_count_minus_one,        // Lane count minus one.
	output wire [3:0] lane_enable,                 // One bit per active lane.
	output wire [4:0] multiframe_length_minus_one, // Frames per multiframe minus one.
	output wire       alignment_sequence_disable,  // Suppress lane alignment sequence.
	output wire       lane_monitor_disable,        // Lane alignment monitor off.
	output wire       frame_monitor_disable,       // Frame alignment monitor off.
	output wire       divider_reset_disable,       // Dividers ignore SYSREF or SYNC.
	output wire       scrambler_enable,            // Payload scrambler on.
	output wire       sample_enable,               // One pulse per converter sample.
	output wire       overflow_out,                // Gated overflow indicator.
	output wire       divider_reset                // One-cycle divider reset pulse.
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function [3:0] lane_mask;
		input [2:0] code;
		begin
			case (code)
				3'h0: lane_mask = 4'h1;
				3'h1: lane_mask = 4'h3;
				3'h2: lane_mask = 4'h7;
				default: lane_mask = 4'hF;
			endcase
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	reg  [2:0]  conv_ctrl_q;
	reg  [7:0]  dev_id_q;
	reg  [3:0]  link_bank_identifier_q;
	reg  [2:0]  lanes_q;
	reg  [3:0]  lane_en_q;
	reg  [4:0]  kframes_q;
	reg  [5:0]  modes_q;
	reg  [14:0] in_q;
	reg  [4:0]  cnt_q;
	reg         cmd_rd_q;
	reg  [6:0]  cmd_addr_q;
	reg  [7:0]  out_q;
	reg         sdo_oe_q;
	reg         sck_prev_q;
	reg         sysref_prev_q;
	reg         sync_prev_q;
	reg         div_rst_q;
	reg         sample_en_q;
	reg         overflow_q;
	reg  [7:0]  rd_data;
	wire [4:0]  pins_f;
	wire        cs_f;
	wire        sck_f;
	wire        sdi_f;
	wire        sysref_f;
	wire        sync_f;
	wire        sck_rise;
	wire        sck_fall;
	wire [6:0]  cmd_addr;
	wire [7:0]  wr_data;

	ajlc_pin_filter #(
		.WIDTH     (5),
		.RESET_VAL (`AJLC_RST_PINS)
	) u_pins (
		.core_clk (core_clk),
		.rstn     (rstn),
		.pin_in   ({sync_n, sysref, spi_sdi, spi_sck, spi_cs_n}),
		.pin_out  (pins_f)
	);

	assign cs_f     = pins_f[0];
	assign sck_f    = pins_f[1];
	assign sdi_f    = pins_f[2];
	assign sysref_f = pins_f[3];
	assign sync_f   = pins_f[4];
	assign sck_rise = ~cs_f & sck_f & ~sck_prev_q;
	assign sck_fall = ~cs_f & ~sck_f & sck_prev_q;
	assign cmd_addr = {in_q[5:0], sdi_f};
	assign wr_data  = {in_q[6:0], sdi_f};

	// ****************************************************************
	// Read-back multiplexer
	// ****************************************************************
	// Unused bits and unmapped addresses read as zero.
	always @* begin
		rd_data = 8'h00;
		case (cmd_addr)
			`AJLC_ADDR_CONVERTER_CONTROL: rd_data = {5'h00, conv_ctrl_q};
			`AJLC_ADDR_LINK_DEVICE_IDENTIFIER:         rd_data = dev_id_q;
			`AJLC_ADDR_LINK_BANK_IDENTIFIER:           rd_data = {4'h0, link_bank_identifier_q};
			`AJLC_ADDR_LANE_COUNT:        rd_data = {5'h00, lanes_q};
			`AJLC_ADDR_MULTIFRAME_LEN:    rd_data = {3'h0, kframes_q};
			`AJLC_ADDR_LINK_MODES:        rd_data = {2'h0, modes_q};
			default:                      rd_data = 8'h00;
		endcase
	end

	// ****************************************************************
	// Serial frame: R/W bit, seven address bits, eight data bits
	// ****************************************************************
	// Every pin edge is seen four core cycles late, so each serial clock
	// phase must last at least six core cycles for this port to keep up.
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			in_q       <= 15'h0000;
			cnt_q      <= 5'h00;
			cmd_rd_q   <= 1'b0;
			cmd_addr_q <= 7'h00;
			out_q      <= 8'h00;
			sdo_oe_q   <= 1'b0;
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_f;
			if (cs_f) begin
				cnt_q    <= 5'h00;
				sdo_oe_q <= 1'b0;
			end else if (sck_rise && cnt_q != `AJLC_FRAME_DONE) begin
				in_q  <= {in_q[13:0], sdi_f};
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == `AJLC_FRAME_CMD_LAST) begin
					cmd_rd_q   <= in_q[6];
					cmd_addr_q <= cmd_addr;
					out_q      <= rd_data;
				end
			end else if (sck_fall) begin
				if (cmd_rd_q && cnt_q > `AJLC_FRAME_CMD_LAST &&
				    cnt_q != `AJLC_FRAME_DONE) begin
					sdo_oe_q <= ~out_q[7];
					out_q    <= {out_q[6:0], 1'b0};
				end else begin
					sdo_oe_q <= 1'b0;
				end
			end
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			conv_ctrl_q <= `AJLC_RST_CONVERTER_CONTROL;
			dev_id_q    <= `AJLC_RST_LINK_DEVICE_IDENTIFIER;
			link_bank_identifier_q   <= `AJLC_RST_LINK_BANK_IDENTIFIER;
			lanes_q     <= `AJLC_RST_LANE_COUNT;
			lane_en_q   <= `AJLC_RST_LANE_ENABLE;
			kframes_q   <= `AJLC_RST_MULTIFRAME_LEN;
			modes_q     <= `AJLC_RST_LINK_MODES;
		end else begin
			lane_en_q <= lane_mask(lanes_q);
			if (sck_rise && cnt_q == `AJLC_FRAME_DATA_LAST && !cmd_rd_q) begin
				case (cmd_addr_q)
					`AJLC_ADDR_CONVERTER_CONTROL: conv_ctrl_q <= wr_data[2:0];
					`AJLC_ADDR_LINK_DEVICE_IDENTIFIER:         dev_id_q    <= wr_data;
					`AJLC_ADDR_LINK_BANK_IDENTIFIER:           link_bank_identifier_q   <= wr_data[3:0];
					`AJLC_ADDR_LANE_COUNT:        lanes_q     <= wr_data[2:0];
					`AJLC_ADDR_MULTIFRAME_LEN:    kframes_q   <= wr_data[4:0];
					`AJLC_ADDR_LINK_MODES: begin
						// The reserved bit is never stored and always reads zero.
						modes_q <= wr_data[5:0] &
						           ~(6'h01 << `AJLC_BIT_RESERVED_ZERO);
					end
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Clock halving, overflow gate and divider reset
	// ****************************************************************
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sample_en_q   <= 1'b1;
			overflow_q    <= 1'b0;
			sysref_prev_q <= 1'b0;
			sync_prev_q   <= 1'b1;
			div_rst_q     <= 1'b0;
		end else begin
			// Halving takes every second converter clock as a sample.
			if (conv_ctrl_q[`AJLC_BIT_CLOCK_HALVING]) begin
				sample_en_q <= ~sample_en_q;
			end else begin
				sample_en_q <= 1'b1;
			end
			overflow_q    <= overflow_raw & conv_ctrl_q[`AJLC_BIT_OVERFLOW_EN];
			sysref_prev_q <= sysref_f;
			sync_prev_q   <= sync_f;
			div_rst_q     <= ~modes_q[`AJLC_BIT_DIV_RESET_DIS] &
			                 (((subclass_select == `AJLC_SUBCLASS_1) &
			                   sysref_f & ~sysref_prev_q) |
			                  ((subclass_select == `AJLC_SUBCLASS_2) &
			                   sync_f & ~sync_prev_q));
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign spi_sdo_o                   = 1'b0;
	assign spi_sdo_oe                  = sdo_oe_q;
	assign clock_halving_select        = conv_ctrl_q[`AJLC_BIT_CLOCK_HALVING];
	assign overflow_output_enable      = conv_ctrl_q[`AJLC_BIT_OVERFLOW_EN];
	assign duty_stabilizer_enable      = conv_ctrl_q[`AJLC_BIT_DUTY_STAB_EN];
	assign link_device_identifier      = dev_id_q;
	assign link_bank_identifier        = link_bank_identifier_q;
	assign lane_count_minus_one        = lanes_q;
	assign lane_enable                 = lane_en_q;
	assign multiframe_length_minus_one = kframes_q;
	assign alignment_sequence_disable  = modes_q[`AJLC_BIT_ALIGN_SEQ_DIS];
	assign lane_monitor_disable        = modes_q[`AJLC_BIT_LANE_MON_DIS];
	assign frame_monitor_disable       = modes_q[`AJLC_BIT_FRAME_MON_DIS];
	assign divider_reset_disable       = modes_q[`AJLC_BIT_DIV_RESET_DIS];
	assign scrambler_enable            = modes_q[`AJLC_BIT_SCRAMBLER_EN];
	assign sample_enable               = sample_en_q;
	assign overflow_out                = overflow_q;
	assign divider_reset               = div_rst_q;

endmodule // ajlc_link_config

`default_nettype wire

// ==== tb/ajlc_link_config_properties.sv ====
// Port checks for the link configuration bank.
`timescale 1ns/10ps
`default_nettype none

module ajlc_link_config_checker (
	input wire logic       core_clk, // Clock.
	input wire logic       rstn, // Reset.
	input wire logic       spi_cs_n, // Select.
	input wire logic       sysref, // Reference.
	input wire logic       sync_n, // Sync.
	input wire logic [2:0] subclass_select, // Subclass.
	input wire logic       overflow_raw, // Raw flag.
	input wire logic       clock_halving_select, // Halving.
	input wire logic       overflow_output_enable, // Gate.
	input wire logic [7:0] link_device_identifier, // Identifier.
	input wire logic [2:0] lane_count_minus_one, // Lanes.
	input wire logic [3:0] lane_enable, // Mask.
	input wire logic [4:0] multiframe_length_minus_one, // Length.
	input wire logic       alignment_sequence_disable, // Sequence.
	input wire logic       divider_reset_disable, // Block.
	input wire logic       scrambler_enable, // Scrambler.
	input wire logic       sample_enable, // Strobe.
	input wire logic       overflow_out, // Overflow.
	input wire logic       divider_reset // Pulse.
);
	// *****
	// Helpers
	// *****
	localparam logic [20:0] CFG_RST = 21'h000178;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	logic        first_q;
	logic  [3:0] idle_q;
	wire  [20:0] cfg = {clock_halving_select, overflow_output_enable, link_device_identifier,
		lane_count_minus_one, multiframe_length_minus_one, alignment_sequence_disable,
		divider_reset_disable, scrambler_enable};

	// Idle time lets a write that lands late in a frame settle before the hold check.
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			first_q <= 1'b1;
			idle_q <= 4'h0;
		end else begin
			first_q <= 1'b0;
			if (!spi_cs_n)
				idle_q <= 4'h0;
			else if (idle_q != 4'hF)
				idle_q <= idle_q + 4'h1;
		end
	end

	function automatic logic [3:0] lane_mask(input logic [2:0] c);
		return (c == 3'h0) ? 4'h1 : (c == 3'h1) ? 4'h3 : (c == 3'h2) ? 4'h7 : 4'hF;
	endfunction

	property div_fire_p;
		!divider_reset_disable && ((subclass_select == 3'h1 && $rose(sysref))
			|| (subclass_select == 3'h2 && $rose(sync_n))) |-> ##[2:9] divider_reset;
	endproperty

	init_default_a: assert property (first_q |-> cfg == CFG_RST)
		else $error("config outputs off their defaults after reset");
	cfg_hold_a: assert property (idle_q > 4'h5 |-> $stable(cfg))
		else $error("config changed while the port was idle");
	lane_map_a: assert property (
		lane_enable == lane_mask($past(lane_count_minus_one)))
		else $error("lane mask does not follow lane count");
	ovf_gate_a: assert property (
		overflow_out == $past(overflow_raw & overflow_output_enable))
		else $error("overflow output not gated by its enable");
	half_toggle_a: assert property (
		clock_halving_select && $past(clock_halving_select)
		|-> sample_enable != $past(sample_enable))
		else $error("sample strobe not halving");
	full_rate_a: assert property (
		!$past(clock_halving_select) && !$past(clock_halving_select, 2)
		|-> sample_enable)
		else $error("sample strobe dropped at full rate");
	div_fire_a: assert property (div_fire_p)
		else $error("divider reset missing after reference edge");
	div_block_a: assert property (
		divider_reset |-> !divider_reset_disable
		&& (subclass_select == 3'h1 || subclass_select == 3'h2))
		else $error("divider reset while blocked");
	div_single_a: assert property (divider_reset |=> !divider_reset)
		else $error("divider reset longer than one cycle");

	cover property (divider_reset);
	cover property (lane_enable == 4'hF);
	cover property (overflow_out);
endmodule // ajlc_link_config_checker

`default_nettype wire

// ==== tb/ajlc_spi_host.sv ====
// Serial-port host model that frames register reads and writes.
`timescale 1ns/10ps
`default_nettype none

module ajlc_spi_host (
	input  wire logic core_clk, // Clock.
	input  wire logic sdo_oe, // Device pulls data out low.
	input  wire logic sdo_lvl, // Level while pulled.
	output var  logic cs_n, // Chip select.
	output var  logic sck, // Serial clock, idle low.
	output var  logic sdi // Serial data to the device.
);
	// The data-out line has a pull-up, so a released pin reads one.
	wire sdo = sdo_oe ? sdo_lvl : 1'b1;

	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
	end

	// Eight core cycles per serial phase leave margin over the six the filter needs.
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
		input int nb, output logic [7:0] rdat);
		logic [15:0] word;
		word = {rd, a, wd};
		rdat = 8'h00;
		cs_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		for (int i = 0; i < nb; i++) begin
			sdi <= word[15 - i];
			repeat (8) @(posedge core_clk);
			sck <= 1'b1;
			if (i >= 8)
				rdat = {rdat[6:0], sdo};
			repeat (8) @(posedge core_clk);
			sck <= 1'b0;
		end
		repeat (2) @(posedge core_clk);
		cs_n <= 1'b1;
		sdi <= ~sdi;
		repeat (8) @(posedge core_clk);
	endtask
endmodule // ajlc_spi_host

`default_nettype wire

// ==== tb/ajlc_link_config_tb_top.sv ====
// Random and directed bench for the link configuration bank.
`timescale 1ns/10ps
`default_nettype none

module ajlc_link_config_tb_top;
	// *****
	// Stimulus and expectations
	// *****
	logic        core_clk = 1'b0, rstn = 1'b0, sysref = 1'b0, sync_n = 1'b1, overflow_raw = 1'b0;
	logic  [2:0] subclass_select = 3'h0;
	logic [31:0] seed = 32'h9AAEAB47;
	logic  [7:0] sh [0:127];
	logic  [7:0] rd, d;
	logic        r1, r2, s;
	logic [14:0] corner [12] = '{15'h06E8, 15'h061F, 15'h0503, 15'h0501, 15'h03FF, 15'h04FF,
		15'h02FF, 15'h0720, 15'h0710, 15'h0708, 15'h0702, 15'h0701};
	int          error_cnt = 0, tests_run = 0, cyc = 0, pulse_cnt = 0;
	wire         spi_cs_n, spi_sck, spi_sdi, spi_sdo_o, spi_sdo_oe, clock_halving_select;
	wire         overflow_output_enable, duty_stabilizer_enable, alignment_sequence_disable;
	wire         lane_monitor_disable, frame_monitor_disable, divider_reset_disable;
	wire         scrambler_enable, sample_enable, overflow_out, divider_reset;
	wire   [7:0] link_device_identifier;
	wire   [3:0] link_bank_identifier, lane_enable;
	wire   [2:0] lane_count_minus_one;
	wire   [4:0] multiframe_length_minus_one;
	wire   [7:0] v2 = {5'h00, clock_halving_select, overflow_output_enable,
		duty_stabilizer_enable};
	wire   [7:0] v7 = {2'h0, alignment_sequence_disable, lane_monitor_disable,
		frame_monitor_disable, 1'b0, divider_reset_disable, scrambler_enable};

	ajlc_link_config u_dut (.core_clk, .rstn, .spi_cs_n, .spi_sck, .spi_sdi, .spi_sdo_o,
		.spi_sdo_oe, .sysref, .sync_n, .subclass_select, .overflow_raw, .clock_halving_select,
		.overflow_output_enable, .duty_stabilizer_enable, .link_device_identifier,
		.link_bank_identifier, .lane_count_minus_one, .lane_enable, .multiframe_length_minus_one,
		.alignment_sequence_disable, .lane_monitor_disable, .frame_monitor_disable,
		.divider_reset_disable, .scrambler_enable, .sample_enable, .overflow_out, .divider_reset);
	ajlc_spi_host u_host (.core_clk, .sdo_oe(spi_sdo_oe), .sdo_lvl(spi_sdo_o), .cs_n(spi_cs_n),
		.sck(spi_sck), .sdi(spi_sdi));

	always #20 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (divider_reset === 1'b1)
			pulse_cnt <= pulse_cnt + 1;
		if (cyc == 50000) begin
			error_cnt++;
			give_verdict();
		end
	end

	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	function automatic logic [7:0] fmask(input logic [6:0] a);
		case (a)
			7'h02, 7'h05: return 8'h07;
			7'h03: return 8'hFF;
			7'h04: return 8'h0F;
			7'h06: return 8'h1F;
			7'h07: return 8'h3B;
			default: return 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] lane_map(input logic [2:0] c);
		return (c == 3'h0) ? 8'h01 : (c == 3'h1) ? 8'h03 : (c == 3'h2) ? 8'h07 : 8'h0F;
	endfunction

	task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] dat);
		u_host.xfer(1'b0, a, dat, 16, rd);
		sh[a] = dat & fmask(a);
	endtask

	task automatic rd_chk(input logic [6:0] a);
		u_host.xfer(1'b1, a, 8'h00, 16, rd);
		chk("readback", rd, sh[a]);
	endtask

	task automatic check_ports();
		chk("converter control", v2, sh[2]);
		chk("link_device_identifier", link_device_identifier, sh[3]);
		chk("link_bank_identifier", {4'h0, link_bank_identifier}, sh[4]);
		chk("lane count", {5'h00, lane_count_minus_one}, sh[5]);
		chk("lane enable", {4'h0, lane_enable}, lane_map(sh[5][2:0]));
		chk("multiframe", {3'h0, multiframe_length_minus_one}, sh[6]);
		chk("link modes", v7, sh[7]);
	endtask

	// Reset pulse of n cycles, then every register must read back its default.
	task automatic pulse_reset(input int n);
		rstn <= 1'b0;
		repeat (n) @(posedge core_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 128; a++)
			sh[a] = (a == 5) ? 8'h01 : (a == 6) ? 8'h0F : 8'h00;
		repeat (6) @(posedge core_clk);
		check_ports();
		for (int a = 1; a < 10; a++)
			rd_chk(7'(a));
	endtask

	task automatic div_case(input logic [2:0] sc, input int n);
		int p0;
		subclass_select <= sc;
		sync_n <= 1'b0;
		repeat (10) @(posedge core_clk);
		sync_n <= 1'b1;
		sysref <= 1'b1;
		p0 = pulse_cnt;
		repeat (16) @(posedge core_clk);
		sysref <= 1'b0;
		chk("divider pulses", 8'(pulse_cnt - p0), 8'(n));
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		pulse_reset(16);
		$display("reset values done");
		for (int n = 0; n < 3; n++) begin
			for (int a = 1; a < 10; a++) begin
				d = rnd();
				if (a == 6)
					d[3] = d[3] | ~d[4];
				if (a == 7)
					d[2] = 1'b0;
				wr(7'(a), d);
			end
			check_ports();
			for (int a = 1; a < 10; a++)
				rd_chk(7'(a));
		end
		$display("random writes done");
		foreach (corner[i]) begin
			wr(corner[i][14:8], corner[i][7:0]);
			check_ports();
			rd_chk(corner[i][14:8]);
		end
		u_host.xfer(1'b0, 7'h03, ~sh[3], 12, rd);
		u_host.xfer(1'b0, 7'h07, 8'h39, 15, rd);
		rd_chk(7'h03);
		rd_chk(7'h07);
		$display("corners and aborts done");
		wr(7'h07, 8'h00);
		div_case(3'h1, 1);
		div_case(3'h2, 1);
		div_case(3'h0, 0);
		wr(7'h07, 8'h02);
		div_case(3'h1, 0);
		div_case(3'h2, 0);
		$display("divider reset done");
		// Outputs are read at the falling edge, once the rising edge has settled them.
		for (int e = 0; e < 2; e++) begin
			wr(7'h02, e ? 8'h06 : 8'h00);
			@(negedge core_clk);
			r2 = overflow_raw;
			s = sample_enable;
			for (int i = 0; i < 12; i++) begin
				@(posedge core_clk);
				r1 = ^rnd();
				overflow_raw <= r1;
				@(negedge core_clk);
				chk("overflow out", {7'h00, overflow_out}, {7'h00, r2 & e[0]});
				chk("sample strobe", {7'h00, sample_enable}, {7'h00, e[0] ? ~s : 1'b1});
				s = sample_enable;
				r2 = r1;
			end
		end
		$display("overflow and halving done");
		@(posedge core_clk);
		pulse_reset(4);
		$display("mid-run reset done");
		give_verdict();
	end
endmodule // ajlc_link_config_tb_top

bind ajlc_link_config ajlc_link_config_checker u_checker (.core_clk, .rstn, .spi_cs_n, .sysref,
	.sync_n, .subclass_select, .overflow_raw, .clock_halving_select, .overflow_output_enable,
	.link_device_identifier, .lane_count_minus_one, .lane_enable, .multiframe_length_minus_one,
	.alignment_sequence_disable, .divider_reset_disable, .scrambler_enable, .sample_enable,
	.overflow_out, .divider_reset);

`default_nettype wire
